// [conflict_timer.sv]
// shared constants of the signal conflict monitor and its qualification timer
// ================================================================
// constants
package cm_pkg;
   localparam int NCH    = 12;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MS_W   = 14;
   localparam int PRE_W  = 16;

   // register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_REDFAIL = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CLEAR   = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_CONFL   = 8'h10;
   localparam logic [ADDR_W-1:0] REG_OVERLAP = 8'h14;
   localparam logic [1:0]        COMPAT_PAGE = 2'h1;   // 0x40..0x6c, one row per channel

   // control register fields
   localparam int CTRL_MINCLR_BIT = 0;
   localparam int CTRL_WDOG_BIT   = 1;
   localparam int CTRL_GWY_BIT    = 2;
   localparam int CTRL_VSRED_BIT  = 3;
   localparam int CTRL_FSEL_LSB   = 4;
   localparam logic [3:0] OPT_RST   = 4'hf;
   localparam logic [3:0] FSEL_RST  = 4'h5;
   localparam int CLEAR_MANUAL_BIT = 0;

   // status register fields
   localparam int ST_CONFLICT = 0;
   localparam int ST_REDFAIL  = 1;
   localparam int ST_MINCLR   = 2;
   localparam int ST_WDOG     = 3;
   localparam int ST_GWY      = 4;
   localparam int ST_VSRED    = 5;
   localparam int ST_HEALTH   = 6;
   localparam int ST_SUPPLY   = 7;
   localparam int ST_CHAIN    = 8;
   localparam int ST_MAINS    = 9;
   localparam int ST_MINFLASH = 10;
   localparam int ST_PERMIT   = 11;
   localparam int ST_HALT     = 12;
   localparam int ST_SYSRST   = 13;
   localparam int ST_CARRY    = 14;

   // synchroniser vector layout
   localparam int SY_RED    = 0;
   localparam int SY_YEL    = 12;
   localparam int SY_GRN    = 24;
   localparam int SY_WALK   = 36;
   localparam int SY_HEALTH = 48;
   localparam int SY_SUPPLY = 49;
   localparam int SY_CHAIN  = 50;
   localparam int SY_MAINS  = 51;
   localparam int SY_TOGGLE = 52;
   localparam int SY_MANUAL = 53;
   localparam int SY_CARRY  = 54;
   localparam int SYNC_W    = 55;

   // timing, times in ms, counts in 1 ms ticks
   localparam int CLK_HZ          = 40_000_000;
   localparam int TICK_HZ         = 1000;
   localparam int TICK_CYCLES     = CLK_HZ / TICK_HZ;
   localparam int CONFLICT_MS     = 325;
   localparam int REDFAIL_MS      = 850;
   localparam int MAINS_MS        = 850;
   localparam int OVERLAP_MS      = 850;
   localparam int MINCLR_MS       = 2700;
   localparam int SYSRST_MS       = 2500;
   localparam int WDOG_MS         = 1000;
   localparam int FSEL_STEP_MS    = 1000;
   localparam int FLASH_MAX_MS    = 15000;
   localparam int CONFLICT_TICKS  = CONFLICT_MS * TICK_HZ / 1000;
   localparam int REDFAIL_TICKS   = REDFAIL_MS * TICK_HZ / 1000;
   localparam int MAINS_TICKS     = MAINS_MS * TICK_HZ / 1000;
   localparam int OVERLAP_TICKS   = OVERLAP_MS * TICK_HZ / 1000;
   localparam int MINCLR_TICKS    = MINCLR_MS * TICK_HZ / 1000;
   localparam int SYSRST_TICKS    = SYSRST_MS * TICK_HZ / 1000;
   localparam int WDOG_TICKS      = WDOG_MS * TICK_HZ / 1000;
   localparam int FSEL_STEP_TICKS = FSEL_STEP_MS * TICK_HZ / 1000;
   localparam int FLASH_MAX_TICKS = FLASH_MAX_MS * TICK_HZ / 1000;
endpackage

// ================================================================
// qualification timer: fire stands once cond held LIMIT ticks unbroken
module conflict_timer
   import cm_pkg::*;
#(
   parameter int LIMIT = 850,
   parameter int W     = MS_W
) (
   input  wire logic clk,    // system clock
   input  wire logic srst,   // sync reset
   input  wire logic ce,     // clock enable
   input  wire logic tick,   // 1 ms tick
   input  wire logic cond,   // condition under test
   output logic      fire    // condition qualified
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tstate_t;

   tstate_t st;
   tstate_t next_st;

   always_comb begin
      next_st = st;
      if (!cond) begin
         next_st.cnt = '0;   // any gap restarts qualification
      end else if (tick && st.cnt != W'(LIMIT)) begin
         next_st.cnt = st.cnt + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign fire = cond && (st.cnt == W'(LIMIT));
endmodule

// [signal_conflict_monitor.sv]
// signal conflict monitor: field checks, fault latching, run permit and halt
// ================================================================
//
// Local design decisions: the register addresses and strobed register access.
module signal_conflict_monitor
   import cm_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input  wire logic              clk,            // 40 MHz system clock
   input  wire logic              srst,           // sync reset, active high
   input  wire logic              ce,             // clock enable, freezes all state
   input  wire logic [NCH-1:0]    redIn,          // red field outputs
   input  wire logic [NCH-1:0]    yellowIn,       // yellow field outputs
   input  wire logic [NCH-1:0]    greenIn,        // green field outputs
   input  wire logic [NCH-1:0]    walkIn,         // walk field outputs
   input  wire logic              controllerHealthSignalN, // low while controller healthy
   input  wire logic              supplySense,    // 24 V supply present
   input  wire logic              cardChainSense, // 24 V card chain intact
   input  wire logic              mainsLow,       // mains below threshold
   input  wire logic              ctlToggle,      // controller square wave
   input  wire logic              manualResetIn,  // front panel reset button
   input  wire logic              faultCarryIn,   // stored failed state from before power loss
   input  wire logic [ADDR_W-1:0] addr,           // register address
   input  wire logic [DATA_W-1:0] wrData,         // register write data
   input  wire logic              wrEn,           // write strobe
   input  wire logic              rdEn,           // read strobe
   output logic      [DATA_W-1:0] rdData,         // read data, cycle after rdEn
   output logic                   runPermit,      // run-permit relay, high energised
   output logic                   phaseHalt,      // halt phase timing
   output logic                   sysReset,       // system reset to assembly
   output logic                   faultCarryOut   // failed state to keep across power loss
);
   typedef struct packed {
      logic [SYNC_W-1:0]             sync1;
      logic [SYNC_W-1:0]             sync2;
      logic [PRE_W-1:0]              pre;
      logic                          tick;
      logic [MS_W-1:0]               upMs;
      logic [1:0]                    armCnt;
      logic [3:0]                    opt;
      logic [3:0]                    flashSel;
      logic [NCH-1:0][NCH-1:0]       compat;
      logic [NCH-1:0]                prevGreen;
      logic [NCH-1:0][MS_W-1:0]      sinceEnd;
      logic                          prevToggle;
      logic [MS_W-1:0]               wdogMs;
      logic                          prevManual;
      logic [NCH-1:0]                conflictLat;
      logic [NCH-1:0]                redFailLat;
      logic [NCH-1:0]                gwyLat;
      logic [NCH-1:0]                vsRedLat;
      logic                          minClrLat;
      logic                          wdogLat;
      logic                          carryLat;
      logic                          runPermit;
      logic                          phaseHalt;
      logic                          sysReset;
      logic                          faultCarryOut;
      logic [DATA_W-1:0]             rdData;
   } state_t;

   state_t st;
   state_t next_st;

   // ================================================================
   // synchronised views
   logic [NCH-1:0] red;
   logic [NCH-1:0] yel;
   logic [NCH-1:0] grn;
   logic [NCH-1:0] walk;
   logic [NCH-1:0] nonRed;
   logic [NCH-1:0][NCH-1:0] pairOk;
   logic [NCH-1:0] conflictCond;
   logic [NCH-1:0] conflictFire;
   logic [NCH-1:0] redFailFire;
   logic [NCH-1:0] gwyFire;
   logic [NCH-1:0] vsRedFire;
   logic [NCH-1:0] clrViol;
   logic           mainsFire;

   assign red    = st.sync2[SY_RED  +: NCH];
   assign yel    = st.sync2[SY_YEL  +: NCH];
   assign grn    = st.sync2[SY_GRN  +: NCH];
   assign walk   = st.sync2[SY_WALK +: NCH];
   assign nonRed = grn | yel | walk;

   // ================================================================
   // per-channel checks
   genvar gi;
   genvar gj;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         logic [NCH-1:0] clash;
         logic [NCH-1:0] early;
         for (gj = 0; gj < NCH; gj++) begin : g_pair
            if (gi == gj) begin : g_self
               assign pairOk[gi][gj] = 1'b1;
            end else begin : g_other
               assign pairOk[gi][gj] = st.compat[gi][gj] | st.compat[gj][gi];
            end
            assign clash[gj] = nonRed[gj] & ~pairOk[gi][gj];
            // other channel's green ended too recently
            assign early[gj] = ~pairOk[gi][gj] & (st.sinceEnd[gj] < MS_W'(MINCLR_TICKS));
         end
         assign conflictCond[gi] = nonRed[gi] & (|clash);
         assign clrViol[gi] = st.opt[CTRL_MINCLR_BIT] & grn[gi] & ~st.prevGreen[gi]
                              & (|early);

         conflict_timer #(.LIMIT(CONFLICT_TICKS), .W(MS_W)) u_conflict (
            .clk  (clk),
            .srst (srst),
            .ce   (ce),
            .tick (st.tick),
            .cond (conflictCond[gi]),
            .fire (conflictFire[gi])
         );
         conflict_timer #(.LIMIT(REDFAIL_TICKS), .W(MS_W)) u_redfail (
            .clk  (clk),
            .srst (srst),
            .ce   (ce),
            .tick (st.tick),
            .cond (~(nonRed[gi] | red[gi])),
            .fire (redFailFire[gi])
         );
         conflict_timer #(.LIMIT(OVERLAP_TICKS), .W(MS_W)) u_gwy (
            .clk  (clk),
            .srst (srst),
            .ce   (ce),
            .tick (st.tick),
            .cond (st.opt[CTRL_GWY_BIT] & (grn[gi] | walk[gi]) & yel[gi]),
            .fire (gwyFire[gi])
         );
         conflict_timer #(.LIMIT(OVERLAP_TICKS), .W(MS_W)) u_vsred (
            .clk  (clk),
            .srst (srst),
            .ce   (ce),
            .tick (st.tick),
            .cond (st.opt[CTRL_VSRED_BIT] & nonRed[gi] & red[gi]),
            .fire (vsRedFire[gi])
         );
      end
   endgenerate

   conflict_timer #(.LIMIT(MAINS_TICKS), .W(MS_W)) u_mains (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .tick (st.tick),
      .cond (st.sync2[SY_MAINS]),
      .fire (mainsFire)
   );

   // ================================================================
   // next state
   always_comb begin
      logic           manualClr;
      logic           anyLatched;
      logic           liveFault;
      logic           flashDone;
      logic           togEdge;
      logic [MS_W-1:0] flashLimit;
      logic [DATA_W-1:0] status;
      manualClr  = 1'b0;
      anyLatched = 1'b0;
      liveFault  = 1'b0;
      flashDone  = 1'b0;
      togEdge    = 1'b0;
      flashLimit = '0;
      status     = '0;
      next_st = st;

      // two flops on every pin except the register bus
      next_st.sync1 = {faultCarryIn, manualResetIn, ctlToggle, mainsLow, cardChainSense,
                       supplySense, controllerHealthSignalN, walkIn, greenIn, yellowIn, redIn};
      next_st.sync2 = st.sync1;

      // single 1 ms timebase
      next_st.tick = 1'b0;
      if (st.pre >= PRE_W'(TICK_DIV - 1)) begin
         next_st.pre  = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.pre = st.pre + PRE_W'(1);
      end
      if (st.tick && st.upMs != MS_W'(FLASH_MAX_TICKS)) begin
         next_st.upMs = st.upMs + MS_W'(1);
      end

      // clearance interval per channel
      next_st.prevGreen = grn;
      for (int i = 0; i < NCH; i++) begin
         if (grn[i]) begin
            next_st.sinceEnd[i] = MS_W'(MINCLR_TICKS);
         end else if (st.prevGreen[i]) begin
            next_st.sinceEnd[i] = '0;
         end else if (st.tick && st.sinceEnd[i] != MS_W'(MINCLR_TICKS)) begin
            next_st.sinceEnd[i] = st.sinceEnd[i] + MS_W'(1);
         end
      end

      // watchdog; counter parked while option is off so enabling never trips at once
      next_st.prevToggle = st.sync2[SY_TOGGLE];
      togEdge = st.sync2[SY_TOGGLE] ^ st.prevToggle;
      if (!st.opt[CTRL_WDOG_BIT] || togEdge) begin
         next_st.wdogMs = '0;
      end else if (st.tick && st.wdogMs != MS_W'(WDOG_TICKS)) begin
         next_st.wdogMs = st.wdogMs + MS_W'(1);
      end

      // manual reset from button edge or register
      next_st.prevManual = st.sync2[SY_MANUAL];
      manualClr = st.sync2[SY_MANUAL] & ~st.prevManual;
      if (wrEn && addr == REG_CLEAR && wrData[CLEAR_MANUAL_BIT]) begin
         manualClr = 1'b1;
      end

      // latched faults: a new set wins over a clear in the same cycle
      next_st.conflictLat = (manualClr ? '0 : st.conflictLat) | conflictFire;
      next_st.redFailLat  = (manualClr ? '0 : st.redFailLat) | redFailFire;
      next_st.gwyLat      = (manualClr ? '0 : st.gwyLat) | gwyFire;
      next_st.vsRedLat    = (manualClr ? '0 : st.vsRedLat) | vsRedFire;
      next_st.minClrLat   = (st.minClrLat & ~manualClr) | (|clrViol);
      next_st.wdogLat     = (st.wdogLat & ~manualClr)
                            | (st.opt[CTRL_WDOG_BIT] && st.wdogMs == MS_W'(WDOG_TICKS));

      // carried failure picked up once the pin synchroniser has filled
      if (st.armCnt != 2'h3) begin
         next_st.armCnt = st.armCnt + 2'h1;
      end
      next_st.carryLat = st.carryLat & ~manualClr;
      if (st.armCnt == 2'h2 && st.sync2[SY_CARRY]) begin
         next_st.carryLat = 1'b1;
      end

      anyLatched = (|st.conflictLat) | (|st.redFailLat) | (|st.gwyLat) | (|st.vsRedLat)
                   | st.minClrLat | st.wdogLat | st.carryLat;
      // baseline non-latching checks, not gated by any option
      liveFault = st.sync2[SY_HEALTH]
                  | ~st.sync2[SY_SUPPLY]
                  | ~st.sync2[SY_CHAIN]
                  | mainsFire;

      flashLimit = MS_W'(FSEL_STEP_TICKS) * MS_W'(st.flashSel);
      flashDone  = st.upMs >= flashLimit;

      next_st.runPermit     = ~anyLatched & ~liveFault & flashDone;
      next_st.phaseHalt     = anyLatched | liveFault;
      next_st.sysReset      = st.upMs < MS_W'(SYSRST_TICKS);
      next_st.faultCarryOut = anyLatched;

      // register writes
      if (wrEn && addr == REG_CTRL) begin
         next_st.opt      = wrData[3:0];
         next_st.flashSel = wrData[CTRL_FSEL_LSB +: 4];
      end
      if (wrEn && addr[7:6] == COMPAT_PAGE && addr[5:2] < 4'(NCH)) begin
         next_st.compat[addr[5:2]] = wrData[NCH-1:0];
      end

      // register reads, data only in the cycle after the strobe
      status[ST_CONFLICT] = |st.conflictLat;
      status[ST_REDFAIL]  = |st.redFailLat;
      status[ST_MINCLR]   = st.minClrLat;
      status[ST_WDOG]     = st.wdogLat;
      status[ST_GWY]      = |st.gwyLat;
      status[ST_VSRED]    = |st.vsRedLat;
      status[ST_HEALTH]   = st.sync2[SY_HEALTH];
      status[ST_SUPPLY]   = ~st.sync2[SY_SUPPLY];
      status[ST_CHAIN]    = ~st.sync2[SY_CHAIN];
      status[ST_MAINS]    = mainsFire;
      status[ST_MINFLASH] = ~flashDone;
      status[ST_PERMIT]   = st.runPermit;
      status[ST_HALT]     = st.phaseHalt;
      status[ST_SYSRST]   = st.sysReset;
      status[ST_CARRY]    = st.carryLat;
      next_st.rdData = '0;
      if (rdEn) begin
         if (addr == REG_CTRL) begin
            next_st.rdData = {24'h000000, st.flashSel, st.opt};
         end else if (addr == REG_STATUS) begin
            next_st.rdData = status;
         end else if (addr == REG_REDFAIL) begin
            next_st.rdData = {20'h00000, st.redFailLat};
         end else if (addr == REG_CONFL) begin
            next_st.rdData = {20'h00000, st.conflictLat};
         end else if (addr == REG_OVERLAP) begin
            next_st.rdData = {8'h00, st.vsRedLat, st.gwyLat};
         end else if (addr[7:6] == COMPAT_PAGE && addr[5:2] < 4'(NCH)) begin
            next_st.rdData = {20'h00000, st.compat[addr[5:2]]};
         end
      end
   end

   // ================================================================
   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st          <= '0;
         st.opt      <= OPT_RST;
         st.flashSel <= FSEL_RST;
         st.sinceEnd <= {NCH{MS_W'(MINCLR_TICKS)}};
         st.phaseHalt <= 1'b1;
         st.sysReset <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdData        = st.rdData;
   assign runPermit     = st.runPermit;
   assign phaseHalt     = st.phaseHalt;
   assign sysReset      = st.sysReset;
   assign faultCarryOut = st.faultCarryOut;
endmodule

// [cm_asserts.sv]
// checker of the flash, halt and system reset outputs of the conflict monitor
// ================================================================
// checker
module cm_asserts
   import cm_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input wire logic              clk,                     // clock
   input wire logic              srst,                    // sync reset
   input wire logic              ce,                      // clock enable
   input wire logic              controllerHealthSignalN, // high = controller failed
   input wire logic              supplySense,             // 24 V supply
   input wire logic              cardChainSense,          // 24 V chain
   input wire logic              mainsLow,                // mains low
   input wire logic [ADDR_W-1:0] addr,                    // bus address
   input wire logic [DATA_W-1:0] wrData,                  // bus write data
   input wire logic              wrEn,                    // bus write strobe
   input wire logic              runPermit,               // relay
   input wire logic              phaseHalt,               // halt
   input wire logic              sysReset,                // system reset
   input wire logic              faultCarryOut            // latched fault held
);
   logic [31:0] up;
   logic [31:0] lowCnt;
   logic [3:0]  fsel;
   // fsel mirrored from bus writes, since the delay setting is not visible at the ports
   always_ff @(posedge clk) begin
      if (srst) begin
         up <= '0;
         lowCnt <= '0;
         fsel <= FSEL_RST;
      end else if (ce) begin
         up <= up + 32'h1;
         lowCnt <= mainsLow ? lowCnt + 32'h1 : '0;
         if (wrEn && addr == REG_CTRL) fsel <= wrData[CTRL_FSEL_LSB+:4];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_health_flash: assert property (controllerHealthSignalN [*8] |-> !runPermit)
      else $error("permit while health false");
   chk_supply_flash: assert property (!supplySense [*8] |-> !runPermit)
      else $error("permit while supply lost");
   chk_chain_flash: assert property (!cardChainSense [*8] |-> !runPermit)
      else $error("permit while chain broken");
   chk_mains_flash: assert property (lowCnt >= (MAINS_TICKS + 2) * TICK_DIV + 8 |-> !runPermit)
      else $error("permit while mains low");
   chk_halt_permit: assert property (runPermit |-> !phaseHalt)
      else $error("halt while permit");
   chk_latched_flash: assert property (faultCarryOut |-> !runPermit)
      else $error("permit with latched fault");
   chk_min_flash: assert property ($rose(runPermit) |-> up + TICK_DIV >= fsel * FSEL_STEP_TICKS * TICK_DIV)
      else $error("permit before min flash");
   chk_sysrst_time: assert property ($fell(sysReset) |-> up >= (SYSRST_TICKS - 1) * TICK_DIV
      && up <= (SYSRST_TICKS + 1) * TICK_DIV + 8)
      else $error("system reset length wrong");
   cov_drop: cover property ($fell(runPermit));
   cov_rise: cover property ($rose(runPermit));
   cov_sysrst: cover property ($fell(sysReset));
endmodule

bind signal_conflict_monitor cm_asserts #(.TICK_DIV(TICK_DIV)) chk (.clk(clk), .srst(srst), .ce(ce),
   .controllerHealthSignalN(controllerHealthSignalN), .supplySense(supplySense), .cardChainSense(cardChainSense),
   .mainsLow(mainsLow), .addr(addr), .wrData(wrData), .wrEn(wrEn), .runPermit(runPermit),
   .phaseHalt(phaseHalt), .sysReset(sysReset), .faultCarryOut(faultCarryOut));

// [ctl_model.sv]
// controller unit and field output model
module ctl_model #(
   parameter int HALF = 400
) (
   input  wire logic        clk,      // clock
   input  wire logic        stop,     // freeze toggle
   input  wire logic        fail,     // controller failed
   input  wire logic [11:0] grn,      // greens on
   input  wire logic [11:0] yel,      // yellows on
   input  wire logic [11:0] wlk,      // walks on
   input  wire logic [11:0] dark,     // channels left unlit
   input  wire logic [11:0] redForce, // reds held on beside any colour
   output logic      [11:0] redIn,    // red outputs
   output logic      [11:0] yellowIn, // yellow outputs
   output logic      [11:0] greenIn,  // green outputs
   output logic      [11:0] walkIn,   // walk outputs
   output logic             toggle,   // square wave
   output logic             healthN   // high = failed
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   initial toggle = 1'b0;
   // wave stands still while stopped, as a hung controller would
   always @(posedge clk) begin
      if (!stop) cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (!stop && cnt == HALF - 1) toggle <= ~toggle;
   end
   assign redIn = ~(grn | yel | wlk | dark) | redForce;
   assign yellowIn = yel;
   assign greenIn = grn;
   assign walkIn = wlk;
   assign healthN = fail;
endmodule

// [signal_conflict_monitor_tb.sv]
// self-checking testbench of the signal conflict monitor
module signal_conflict_monitor_tb
   import cm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TD = 4;
   logic              clk, srst, ce, mainsLow, supplySense, cardChainSense, manualResetIn, faultCarryIn;
   logic              wrEn, rdEn, stop, fail, rdPend, runPermit, phaseHalt, sysReset, faultCarryOut;
   logic              ctlToggle, healthN;
   logic [11:0]       grn, yel, wlk, dark, redForce, redIn, yellowIn, greenIn, walkIn;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData, rdData;
   logic [63:0]       note;
   logic [63:0]       notes[$];
   int                fails = 0, compares = 0, now = 0, t0, ch;

   ctl_model #(.HALF(400)) ctl (.clk(clk), .stop(stop), .fail(fail), .grn(grn), .yel(yel), .wlk(wlk),
      .dark(dark), .redForce(redForce), .redIn(redIn), .yellowIn(yellowIn), .greenIn(greenIn), .walkIn(walkIn),
      .toggle(ctlToggle), .healthN(healthN));
   signal_conflict_monitor #(.TICK_DIV(TD)) DUT (.clk(clk), .srst(srst), .ce(ce), .redIn(redIn),
      .yellowIn(yellowIn), .greenIn(greenIn), .walkIn(walkIn), .controllerHealthSignalN(healthN),
      .supplySense(supplySense), .cardChainSense(cardChainSense), .mainsLow(mainsLow), .ctlToggle(ctlToggle),
      .manualResetIn(manualResetIn), .faultCarryIn(faultCarryIn), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .runPermit(runPermit), .phaseHalt(phaseHalt), .sysReset(sysReset),
      .faultCarryOut(faultCarryOut));

   // ================================================================
   // tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      notes.push_back({m, v});
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
   endtask
   task automatic permit(input logic v);
      check("runPermit", 32'(runPermit), 32'(v));
   endtask
   task automatic setf(input int i, input logic v);
      case (i)
         0: fail <= v;
         1: supplySense <= !v;
         2: cardChainSense <= !v;
         default: mainsLow <= v;
      endcase
   endtask

   // ================================================================
   // clock, read monitor, watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      now <= now + 1;
      rdPend <= rdEn;
      if (rdPend === 1'b1) begin
         note = notes.pop_front();
         check("rdData", rdData & note[63:32], note[31:0]);
      end
   end
   initial begin
      #1_500_000;
      fails++;
      end_of_test;
   end

   // ================================================================
   // scenarios
   initial begin
      {srst, ce, supplySense, cardChainSense} = 4'hf;
      {mainsLow, manualResetIn, faultCarryIn, wrEn, rdEn, stop, fail} = '0;
      {addr, wrData, grn, yel, wlk, dark, redForce} = '0;
      void'($urandom(37));
      cyc(4);
      srst <= 1'b0;
      t0 = now;
      rd(REG_CTRL, 32'hffffffff, 32'h5f);
      rd(8'h20, 32'hffffffff, 32'h0);
      rd(REG_CLEAR, 32'hffffffff, 32'h0);
      while (sysReset !== 1'b0 && now - t0 < 20000) cyc(1);
      check("sysReset", 32'(now - t0 >= 2500 * TD - 8 && now - t0 <= 2500 * TD + 16), 32'h1);
      while (runPermit !== 1'b1 && now - t0 < 30000) cyc(1);
      check("minFlash", 32'(now - t0 >= 5000 * TD - TD), 32'h1);
      permit(1'b1);
      wr(REG_CTRL, 32'h0);
      grn <= 12'h003;
      cyc(300 * TD);
      permit(1'b1);
      cyc(60 * TD);
      permit(1'b0);
      check("phaseHalt", 32'(phaseHalt), 32'h1);
      rd(REG_CONFL, 32'hfff, 32'h3);
      grn <= 12'h0;
      cyc(100);
      permit(1'b0);
      check("faultCarryOut", 32'(faultCarryOut), 32'h1);
      wr(REG_CLEAR, 32'h1);
      cyc(20);
      permit(1'b1);
      check("phaseHalt", 32'(phaseHalt), 32'h0);
      wr(8'h40, 32'h2);
      grn <= 12'h003;
      cyc(400 * TD);
      permit(1'b1);
      grn <= 12'h0;
      ch = $urandom % 12;
      dark <= 12'(1 << ch);
      cyc(900 * TD);
      permit(1'b0);
      rd(REG_REDFAIL, 32'hfff, 32'(1 << ch));
      dark <= 12'h0;
      cyc(100);
      permit(1'b0);
      manualResetIn <= 1'b1;
      cyc(10);
      manualResetIn <= 1'b0;
      cyc(20);
      permit(1'b1);
      // baseline faults with every option off
      for (int i = 0; i < 4; i++) begin
         setf(i, 1'b1);
         cyc(i == 3 ? 800 * TD : 1);
         if (i == 3) permit(1'b1);
         cyc(i == 3 ? 100 * TD : 20);
         permit(1'b0);
         rd(REG_STATUS, 32'(1 << (ST_HEALTH + i)), 32'(1 << (ST_HEALTH + i)));
         setf(i, 1'b0);
         cyc(20);
         permit(1'b1);
      end
      wr(REG_CTRL, 32'(1 << CTRL_WDOG_BIT));
      stop <= 1'b1;
      cyc(1100 * TD);
      permit(1'b0);
      stop <= 1'b0;
      cyc(1000);
      permit(1'b0);
      wr(REG_CLEAR, 32'h1);
      cyc(20);
      permit(1'b1);
      wr(REG_CTRL, 32'(1 << CTRL_MINCLR_BIT));
      grn <= 12'h001;
      cyc(20);
      grn <= 12'h0;
      cyc(100 * TD);
      grn <= 12'h004;
      cyc(10);
      permit(1'b0);
      rd(REG_STATUS, 32'(1 << ST_MINCLR), 32'(1 << ST_MINCLR));
      grn <= 12'h0;
      wr(REG_CLEAR, 32'h1);
      cyc(20);
      permit(1'b1);
      wr(REG_CTRL, 32'(1 << CTRL_GWY_BIT | 1 << CTRL_VSRED_BIT));
      grn <= 12'h001;
      yel <= 12'h003;
      redForce <= 12'h002;
      cyc(900 * TD);
      permit(1'b0);
      rd(REG_OVERLAP, 32'hffffff, 32'h2001);
      grn <= 12'h0;
      yel <= 12'h0;
      redForce <= 12'h0;
      cyc(10);
      wr(REG_CLEAR, 32'h1);
      cyc(20);
      permit(1'b1);
      faultCarryIn <= 1'b1;
      srst <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      cyc(10);
      rd(REG_STATUS, 32'(1 << ST_CARRY), 32'(1 << ST_CARRY));
      cyc(2);
      check("faultCarryOut", 32'(faultCarryOut), 32'h1);
      end_of_test;
   end
endmodule
